/* File: hw/bsba_pkg.sv */
// Purpose: Constants for the block search and byte add engine
// Assumes: One clock state is one clk cycle at 25 MHz
// Notes:   Register map is reached over AXI4-Lite
//
// Behaviour
// - Block move down clears half-carry, parity/overflow, add/subtract; keeps sign and zero.
// - Block move down copies source byte to target, decrements both pointers and counter.
// - Prefixed A1 compares accumulator with source byte, increments pointer, decrements counter.
// - Prefixed A9 compares the same way but decrements pointer and counter.
// - Compares only derive flags; accumulator and memory stay untouched.
// - Zero flag set exactly when accumulator equals the memory byte.
// - Parity/overflow set when decremented counter is nonzero, cleared when zero.
// - Sign from negative difference, half-carry from borrow out of bit 4.
// - Compares set add/subtract and keep carry unchanged.
// - Upward repeat search ends on zero counter or match, else program counter minus two.
// - Downward repeat search ends the same way with pointer decremented.
// - Between repeat iterations pending interrupts are taken and two refresh cycles run.
// - Counter zero at start with no match searches the whole 64 Kbyte range.
// - A repeating iteration lasts 21 clock states (4, 4, 3, 5, 5).
// - A single compare or final iteration lasts 16 clock states (4, 4, 3, 5).
// - Add register adds the selected register to accumulator; select code per table.
// - Opcode c6 adds the immediate byte in 7 clock states (4, 3).
// - Add sets sign, zero, and half-carry from carry out of bit 3.
// - Add sets overflow and carry out of bit 7, clears add/subtract.
package bsba_pkg;
    // ************************************************************
    // Register offsets
    // ************************************************************
    localparam logic [7:0] OFF_CMD    = 8'h00;
    localparam logic [7:0] OFF_STATUS = 8'h04;
    localparam logic [7:0] OFF_ACCFL  = 8'h08;
    localparam logic [7:0] OFF_BC     = 8'h0c;
    localparam logic [7:0] OFF_HL     = 8'h10;
    localparam logic [7:0] OFF_DE     = 8'h14;
    localparam logic [7:0] OFF_PC     = 8'h18;
    localparam logic [1:0] RESP_OKAY  = 2'h0;
    localparam logic [1:0] RESP_SLV   = 2'h2;

    // ************************************************************
    // Opcodes and fields
    // ************************************************************
    localparam logic [7:0] OP_CMP_UP   = 8'ha1;
    localparam logic [7:0] OP_CMP_DN   = 8'ha9;
    localparam logic [7:0] OP_SRCH_UP  = 8'hb1;
    localparam logic [7:0] OP_SRCH_DN  = 8'hb9;
    localparam logic [7:0] OP_MOVE_DN  = 8'hb8;
    localparam logic [7:0] OP_ADD_IMM  = 8'hc6;
    localparam logic [4:0] OP_ADD_REG  = 5'h10;
    localparam logic [2:0] SEL_MEM     = 3'h6;
    localparam int         CMD_PFX_BIT = 8;

    // Flag bit positions
    localparam int FL_S = 7;
    localparam int FL_Z = 6;
    localparam int FL_H = 4;
    localparam int FL_V = 2;
    localparam int FL_N = 1;
    localparam int FL_C = 0;

    // ************************************************************
    // Clock state counts
    // ************************************************************
    localparam logic [4:0] LEN_ADD_REG = 5'h04;
    localparam logic [4:0] LEN_ADD_IMM = 5'h07;
    localparam logic [4:0] LEN_BLOCK   = 5'h10;
    localparam logic [4:0] LEN_REPEAT  = 5'h15;
    localparam logic [4:0] CYC_RD      = 5'h08;
    localparam logic [4:0] CYC_WR      = 5'h0b;
    localparam logic [4:0] CYC_RF0     = 5'h11;
    localparam logic [4:0] CYC_RF1     = 5'h12;
    localparam logic [15:0] PC_BACK    = 16'h0002;

    typedef enum logic [2:0] {K_NONE, K_CMP_UP, K_CMP_DN, K_SRCH_UP, K_SRCH_DN, K_MOVE_DN, K_ADD_REG,
                              K_ADD_IMM} bsba_kind_t;
endpackage

/* File: hw/bsba_top.sv */
// Purpose: Block compare, block move down and 8-bit add execution engine
// Assumes: Memory returns read data one cycle after mem_rd
// Notes:   Software writes a command; engine runs it for its clock states
`timescale 1ns/100ps
`default_nettype none
module bsba_top
    import bsba_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // AXI4-Lite slave
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Byte memory
    output logic [15:0]      mem_addr,
    output logic             mem_rd,
    output logic             mem_wr,
    output logic [7:0]       mem_wdata,
    input  wire logic [7:0]  mem_rdata,
    output logic             mem_rfsh,
    // Interrupt request seen between repeat iterations
    input  wire logic        irq_pending
);
    // ************************************************************
    // Decode helpers
    // ************************************************************
    function automatic bsba_kind_t kind_of(input logic [8:0] c);
        if (c[CMD_PFX_BIT])
        begin
            case (c[7:0])
                OP_CMP_UP:  return K_CMP_UP;
                OP_CMP_DN:  return K_CMP_DN;
                OP_SRCH_UP: return K_SRCH_UP;
                OP_SRCH_DN: return K_SRCH_DN;
                OP_MOVE_DN: return K_MOVE_DN;
                default:    return K_NONE;
            endcase
        end
        if (c[7:0] == OP_ADD_IMM)
            return K_ADD_IMM;
        if (c[7:3] == OP_ADD_REG && c[2:0] != SEL_MEM)
            return K_ADD_REG;
        return K_NONE;
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n, input logic [3:0] s);
        logic [31:0] r;
        r = o;
        for (int i = 0; i < 4; i++)
            if (s[i])
                r[i*8 +: 8] = n[i*8 +: 8];
        return r;
    endfunction

    // ************************************************************
    // State
    // ************************************************************
    logic [15:0] bc_reg, hl_reg, de_reg, pc_reg;
    logic [7:0]  acc_reg, flags_reg, data_reg, imm_reg;
    logic [23:0] cmd_reg;
    bsba_kind_t  kind_reg;
    logic        busy_reg, irq_stop_reg, bad_reg, again_reg;
    logic [4:0]  cyc_reg;
    logic [7:0]  aw_addr_reg, ar_addr_reg;
    logic [31:0] w_data_reg;
    logic [3:0]  w_strb_reg;
    logic        aw_hold_reg, w_hold_reg;

    logic        wr_fire, cmd_go, is_cmp, is_rep, again_now, commit, rd_seen_reg;
    logic [15:0] wr_old;
    logic [31:0] wr_merged;
    logic [15:0] bc_dec;
    logic [8:0]  diff, sum;
    logic [4:0]  nib;
    logic [7:0]  addend, reg_sel, run_len;
    bsba_kind_t  new_kind;

    assign wr_fire  = aw_hold_reg && w_hold_reg && !s_axi_bvalid;
    assign new_kind = kind_of(w_data_reg[8:0]);
    assign cmd_go   = wr_fire && aw_addr_reg == OFF_CMD && !busy_reg && new_kind != K_NONE && w_strb_reg[1:0] == 2'h3;
    assign is_cmp   = kind_reg inside {K_CMP_UP, K_CMP_DN, K_SRCH_UP, K_SRCH_DN};
    assign is_rep   = kind_reg inside {K_SRCH_UP, K_SRCH_DN, K_MOVE_DN};
    assign bc_dec   = bc_reg - 16'h0001;
    // Loop test on the decremented counter, decided in the commit cycle itself
    assign again_now = is_cmp ? (bc_dec != 16'h0000 && acc_reg != data_reg)
                              : (kind_reg == K_MOVE_DN && bc_dec != 16'h0000);
    assign diff     = {1'b0, acc_reg} - {1'b0, data_reg};
    assign nib      = {1'b0, acc_reg[3:0]} + {1'b0, addend[3:0]};
    assign sum      = {1'b0, acc_reg} + {1'b0, addend};

    // Register select for add: B C D E H L from the pairs, 111 accumulator
    always_comb
    begin
        case (cmd_reg[2:0])
            3'h0:    reg_sel = bc_reg[15:8];
            3'h1:    reg_sel = bc_reg[7:0];
            3'h2:    reg_sel = de_reg[15:8];
            3'h3:    reg_sel = de_reg[7:0];
            3'h4:    reg_sel = hl_reg[15:8];
            3'h5:    reg_sel = hl_reg[7:0];
            default: reg_sel = acc_reg;
        endcase
        addend  = (kind_reg == K_ADD_IMM) ? imm_reg : reg_sel;
        run_len = (kind_reg == K_ADD_REG) ? {3'h0, LEN_ADD_REG} :
                  (kind_reg == K_ADD_IMM) ? {3'h0, LEN_ADD_IMM} : {3'h0, LEN_BLOCK};
    end
    assign commit = busy_reg && {3'h0, cyc_reg} == run_len - 8'h01;

    // Old value of the addressed register, so byte strobes merge into it
    always_comb
    begin
        case (aw_addr_reg)
            OFF_ACCFL: wr_old = {flags_reg, acc_reg};
            OFF_BC:    wr_old = bc_reg;
            OFF_HL:    wr_old = hl_reg;
            OFF_DE:    wr_old = de_reg;
            default:   wr_old = pc_reg;
        endcase
    end
    assign wr_merged = merge({16'h0, wr_old}, w_data_reg, w_strb_reg);

    // ************************************************************
    // Sequencer: counts clock states, repeat loops back to cycle 0
    // ************************************************************
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            busy_reg     <= 1'b0;
            cyc_reg      <= 5'h00;
            kind_reg     <= K_NONE;
            imm_reg      <= 8'h00;
            irq_stop_reg <= 1'b0;
        end
        else if (cmd_go)
        begin
            busy_reg     <= 1'b1;
            cyc_reg      <= 5'h00;
            kind_reg     <= new_kind;
            imm_reg      <= w_data_reg[23:16];
            irq_stop_reg <= 1'b0;
        end
        else if (busy_reg)
        begin
            if (commit && !(is_rep && again_now))
                busy_reg <= 1'b0;
            else if (cyc_reg == LEN_REPEAT - 5'h01)
            begin
                // Iteration boundary: an interrupt leaves the loop resumable
                busy_reg     <= !irq_pending;
                irq_stop_reg <= irq_pending;
                cyc_reg      <= 5'h00;
            end
            else
                cyc_reg <= cyc_reg + 5'h01;
        end
    end

    // ************************************************************
    // Memory port: read at third machine cycle, write for the move
    // ************************************************************
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mem_addr  <= 16'h0000;
            mem_rd    <= 1'b0;
            mem_wr    <= 1'b0;
            mem_wdata <= 8'h00;
            mem_rfsh  <= 1'b0;
            data_reg  <= 8'h00;
            rd_seen_reg <= 1'b0;
        end
        else
        begin
            mem_rd   <= busy_reg && (is_cmp || is_rep) && cyc_reg == CYC_RD - 5'h01;
            mem_wr   <= busy_reg && kind_reg == K_MOVE_DN && cyc_reg == CYC_WR - 5'h01;
            mem_rfsh <= busy_reg && (cyc_reg == CYC_RF0 - 5'h01 || cyc_reg == CYC_RF1 - 5'h01);
            if (busy_reg && cyc_reg == CYC_RD - 5'h01)
                mem_addr <= hl_reg;
            else if (busy_reg && cyc_reg == CYC_WR - 5'h01)
                mem_addr <= de_reg;
            mem_wdata <= data_reg;                                   // Only the move writes
            // Memory answers one cycle after the read strobe
            rd_seen_reg <= mem_rd;
            if (rd_seen_reg)
                data_reg <= mem_rdata;
        end
    end

    // ************************************************************
    // Architectural registers: engine commits, software loads when idle
    // ************************************************************
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            acc_reg   <= 8'h00;
            flags_reg <= 8'h00;
            bc_reg    <= 16'h0000;
            hl_reg    <= 16'h0000;
            de_reg    <= 16'h0000;
            pc_reg    <= 16'h0000;
            again_reg <= 1'b0;
        end
        else if (busy_reg)
        begin
            if (cyc_reg == 5'h00)
                pc_reg <= pc_reg + ((kind_reg == K_ADD_REG) ? 16'h0001 : PC_BACK);
            if (commit)
            begin
                if (is_cmp)
                begin
                    // Pointer and counter land after the loop test has read bc_dec in this cycle
                    bc_reg                <= bc_dec;
                    hl_reg                <= (kind_reg inside {K_CMP_UP, K_SRCH_UP}) ? hl_reg + 16'h0001
                                                                                     : hl_reg - 16'h0001;
                    flags_reg[FL_S]       <= diff[7];
                    flags_reg[FL_Z]       <= acc_reg == data_reg;
                    flags_reg[FL_H]       <= acc_reg[3:0] < data_reg[3:0];
                    flags_reg[FL_V]       <= bc_dec != 16'h0000;
                    flags_reg[FL_N]       <= 1'b1;
                    again_reg             <= bc_dec != 16'h0000 && acc_reg != data_reg;
                end
                else if (kind_reg == K_MOVE_DN)
                begin
                    bc_reg          <= bc_dec;
                    hl_reg          <= hl_reg - 16'h0001;
                    de_reg          <= de_reg - 16'h0001;
                    flags_reg[FL_H] <= 1'b0;
                    flags_reg[FL_V] <= 1'b0;
                    flags_reg[FL_N] <= 1'b0;
                    again_reg       <= bc_dec != 16'h0000;
                end
                else
                begin
                    acc_reg         <= sum[7:0];
                    flags_reg[FL_S] <= sum[7];
                    flags_reg[FL_Z] <= sum[7:0] == 8'h00;
                    flags_reg[FL_H] <= nib[4];
                    flags_reg[FL_V] <= acc_reg[7] == addend[7] && sum[7] != acc_reg[7];
                    flags_reg[FL_C] <= sum[8];
                    flags_reg[FL_N] <= 1'b0;
                    again_reg       <= 1'b0;
                end
            end
            if (cyc_reg == LEN_REPEAT - 5'h01)
                pc_reg <= pc_reg - PC_BACK;
        end
        else if (wr_fire)
        begin
            case (aw_addr_reg)
                OFF_ACCFL: {flags_reg, acc_reg} <= wr_merged[15:0];
                OFF_BC:    bc_reg <= wr_merged[15:0];
                OFF_HL:    hl_reg <= wr_merged[15:0];
                OFF_DE:    de_reg <= wr_merged[15:0];
                OFF_PC:    pc_reg <= wr_merged[15:0];
                default:   pc_reg <= pc_reg;
            endcase
        end
    end

    // ************************************************************
    // AXI4-Lite write channel: address and data held until both arrive
    // ************************************************************
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            aw_hold_reg   <= 1'b0;
            w_hold_reg    <= 1'b0;
            aw_addr_reg   <= 8'h00;
            w_data_reg    <= 32'h0;
            w_strb_reg    <= 4'h0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OKAY;
            cmd_reg       <= 24'h0;
            bad_reg       <= 1'b0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_addr_reg   <= s_axi_awaddr;
                aw_hold_reg   <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_data_reg   <= s_axi_wdata;
                w_strb_reg   <= s_axi_wstrb;
                w_hold_reg   <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (wr_fire)
            begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (aw_addr_reg inside {OFF_CMD, OFF_STATUS, OFF_ACCFL, OFF_BC, OFF_HL, OFF_DE,
                                                     OFF_PC}) ? RESP_OKAY : RESP_SLV;
                if (aw_addr_reg == OFF_CMD && !busy_reg)
                begin
                    cmd_reg <= w_data_reg[23:0];
                    bad_reg <= !cmd_go;
                end
            end
            if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid  <= 1'b0;
                aw_hold_reg   <= 1'b0;
                w_hold_reg    <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // ************************************************************
    // AXI4-Lite read channel: one read at a time, answer next cycle
    // ************************************************************
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ar_addr_reg   <= 8'h00;
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0;
            s_axi_rresp   <= RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            ar_addr_reg   <= s_axi_araddr;
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rresp   <= RESP_OKAY;
            case (s_axi_araddr)
                OFF_CMD:    s_axi_rdata <= {8'h0, cmd_reg};
                OFF_STATUS: s_axi_rdata <= {29'h0, bad_reg, irq_stop_reg, busy_reg};
                OFF_ACCFL:  s_axi_rdata <= {16'h0, flags_reg, acc_reg};
                OFF_BC:     s_axi_rdata <= {16'h0, bc_reg};
                OFF_HL:     s_axi_rdata <= {16'h0, hl_reg};
                OFF_DE:     s_axi_rdata <= {16'h0, de_reg};
                OFF_PC:     s_axi_rdata <= {16'h0, pc_reg};
                default:
                begin
                    s_axi_rdata <= 32'h0;
                    s_axi_rresp <= RESP_SLV;
                end
            endcase
        end
        else if (s_axi_rvalid && s_axi_rready)
        begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    chk_cmp_length: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(busy_reg) && kind_reg inside {K_CMP_UP, K_CMP_DN} |-> ##15 busy_reg ##1 !busy_reg)
        else $error("single compare not 16 states");
    chk_add_imm_len: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(busy_reg) && kind_reg == K_ADD_IMM |-> busy_reg[*7] ##1 !busy_reg)
        else $error("immediate add not 7 states");
    chk_repeat_len: assert property (@(posedge clk) disable iff (!rst_n)
        busy_reg && is_rep && commit && again_now |=> again_reg ##5 (cyc_reg == 5'h00 || !busy_reg))
        else $error("repeat iteration not 21 states");
    chk_cmp_keeps: assert property (@(posedge clk) disable iff (!rst_n)
        busy_reg && is_cmp |=> $stable(acc_reg) && !mem_wr)
        else $error("compare altered accumulator or memory");
    chk_zero_match: assert property (@(posedge clk) disable iff (!rst_n)
        commit && is_cmp |=> flags_reg[FL_Z] == (acc_reg == data_reg) && flags_reg[FL_N])
        else $error("compare zero flag wrong");
    chk_carry_kept: assert property (@(posedge clk) disable iff (!rst_n)
        commit && kind_reg != K_ADD_REG && kind_reg != K_ADD_IMM |=> $stable(flags_reg[FL_C]))
        else $error("carry changed by block op");
    chk_count_flag: assert property (@(posedge clk) disable iff (!rst_n)
        commit && is_cmp |=> flags_reg[FL_V] == (bc_reg != 16'h0000) && bc_reg == $past(bc_reg) - 16'h0001)
        else $error("parity flag does not follow counter");
    chk_pc_back: assert property (@(posedge clk) disable iff (!rst_n)
        busy_reg && cyc_reg == LEN_REPEAT - 5'h01 |=> pc_reg == $past(pc_reg) - PC_BACK)
        else $error("program counter not stepped back");
    chk_move_flags: assert property (@(posedge clk) disable iff (!rst_n)
        commit && kind_reg == K_MOVE_DN |=> !flags_reg[FL_H] && !flags_reg[FL_V] && !flags_reg[FL_N]
            && $stable(flags_reg[FL_S]) && $stable(flags_reg[FL_Z]))
        else $error("block move flags wrong");
    chk_add_carry: assert property (@(posedge clk) disable iff (!rst_n)
        commit && kind_reg == K_ADD_IMM |=> flags_reg[FL_C] == $past(sum[8]) && acc_reg == $past(sum[7:0]))
        else $error("add result or carry wrong");
    chk_refresh_two: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(mem_rfsh) |-> mem_rfsh ##1 mem_rfsh ##1 !mem_rfsh)
        else $error("refresh not two cycles");
endmodule
`default_nettype wire

/* File: bench/bsba_mem.sv */
// Purpose: Byte memory on the far side of the engine
// Assumes: Read data is due one cycle after mem_rd
// Notes:   Bench loads and inspects m directly
`timescale 1ns/100ps
`default_nettype none
module bsba_mem (
    // Engine side
    input  wire logic        clk,
    input  wire logic [15:0] mem_addr,
    input  wire logic        mem_rd,
    input  wire logic        mem_wr,
    input  wire logic [7:0]  mem_wdata,
    output var  logic [7:0]  mem_rdata
);
    logic [7:0] m [65536];
    // Data lines flip when not read, so a stale byte never passes as fresh
    always @(posedge clk)
    begin
        if (mem_wr) m[mem_addr] <= mem_wdata;
        mem_rdata <= mem_rd ? m[mem_addr] : ~mem_rdata;
    end
endmodule
`default_nettype wire

/* File: bench/test_bsba_top.sv */
// Purpose: Self-checking bench for the search and add engine
// Assumes: Registers reached by AXI4-Lite
// Notes:   Full 64 Kbyte search is too long to run
`timescale 1ns/100ps
`default_nettype none
module test_bsba_top;
    import bsba_pkg::*;
    logic        clk = 1'h0, rst_n = 1'h0, aw = 1'h0, w = 1'h0, b = 1'h0, ar = 1'h0, r = 1'h0, irq = 1'h0;
    logic [7:0]  awa = 8'h0, ara = 8'h0, mwd, mrd_d;
    logic [31:0] wd = 32'h0, d, rdat, errors = 32'h0, checked = 32'h0, cyc = 32'h0, lst = 32'h0, gap = 32'h0;
    logic [31:0] nrf = 32'h0, n0;
    logic [15:0] ma;
    logic [1:0]  rs, br, rr_;
    logic        awr, wr_, bv, arr, rv, mrd, mwr, rfsh;
    bsba_top i_bsba_top (.clk(clk), .rst_n(rst_n), .s_axi_awaddr(awa), .s_axi_awvalid(aw), .s_axi_awready(awr),
        .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(w), .s_axi_wready(wr_), .s_axi_bresp(br),
        .s_axi_bvalid(bv), .s_axi_bready(b), .s_axi_araddr(ara), .s_axi_arvalid(ar), .s_axi_arready(arr),
        .s_axi_rdata(rdat), .s_axi_rresp(rr_), .s_axi_rvalid(rv), .s_axi_rready(r), .mem_addr(ma), .mem_rd(mrd),
        .mem_wr(mwr), .mem_wdata(mwd), .mem_rdata(mrd_d), .mem_rfsh(rfsh), .irq_pending(irq));
    bsba_mem i_bsba_mem (.clk(clk), .mem_addr(ma), .mem_rd(mrd), .mem_wr(mwr), .mem_wdata(mwd), .mem_rdata(mrd_d));
    always #20 clk = ~clk;
    // Read spacing and refresh count, for iteration timing
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (mrd === 1'h1)
        begin
            gap <= cyc - lst;
            lst <= cyc;
        end
        if (rfsh === 1'h1) nrf <= nrf + 1;
    end
    // ********
    // Bus tasks
    // ********
    task automatic chk(input logic [31:0] g, e);
        checked = checked + 1;
        if (g !== e)
        begin
            errors = errors + 1;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic put(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        awa <= a;
        wd <= v;
        {aw, w, b} <= 3'h7;
        do
        begin
            @(posedge clk);
            if (aw && awr) aw <= 1'h0;
            if (w && wr_) w <= 1'h0;
        end
        while (bv !== 1'h1);
        b <= 1'h0;
    endtask
    task automatic get(input logic [7:0] a);
        @(posedge clk);
        ara <= a;
        {ar, r} <= 2'h3;
        do
        begin
            @(posedge clk);
            if (ar && arr) ar <= 1'h0;
        end
        while (rv !== 1'h1);
        d = rdat;
        rs = rr_;
        r <= 1'h0;
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        get(a);
        chk(d, e);
    endtask
    task automatic ld(input logic [15:0] af, bc, hl, de);
        put(OFF_ACCFL, {16'h0, af});
        put(OFF_BC, {16'h0, bc});
        put(OFF_HL, {16'h0, hl});
        put(OFF_DE, {16'h0, de});
    endtask
    // Busy is polled, since the engine length varies with the command
    task automatic run(input logic [31:0] c);
        put(OFF_CMD, c);
        do get(OFF_STATUS); while (d[0] !== 1'h0);
    endtask
    // Flags S Z - H - V N C above the sum
    function automatic logic [15:0] add(input logic [7:0] a, x);
        logic [8:0] s;
        s = a + x;
        return {s[7], s[7:0] == 8'h0, 1'h0, ({1'h0, a[3:0]} + x[3:0]) > 5'hf, 1'h0,
                a[7] == x[7] && s[7] != a[7], 1'h0, s[8], s[7:0]};
    endfunction
    task automatic end_of_test;
        $display("Mismatches %0d, comparisons %0d", errors, checked);
        if (errors == 0 && checked != 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // ********
    // Scenarios
    // ********
    task automatic t_cmp;
        ld(16'h013b, 16'h1, 16'h1111, 16'h0);
        i_bsba_mem.m[16'h1111] = 8'h3b;
        run({24'h1, OP_CMP_UP});
        rc(OFF_ACCFL, 32'h433b);
        rc(OFF_HL, 32'h1112);
        rc(OFF_BC, 32'h0);
        chk({24'h0, i_bsba_mem.m[16'h1111]}, 32'h3b);
        ld(16'h0110, 16'h0, 16'h2000, 16'h0);
        i_bsba_mem.m[16'h2000] = 8'h01;
        run({24'h1, OP_CMP_DN});
        rc(OFF_ACCFL, 32'h1710);
        rc(OFF_HL, 32'h1fff);
        rc(OFF_BC, 32'hffff);
    endtask
    task automatic t_search;
        ld(16'h01f3, 16'h7, 16'h1111, 16'h0);
        put(OFF_PC, 32'h100);
        i_bsba_mem.m[16'h1111] = 8'h52;
        i_bsba_mem.m[16'h1112] = 8'h00;
        i_bsba_mem.m[16'h1113] = 8'hf3;
        n0 = nrf;
        run({24'h1, OP_SRCH_UP});
        rc(OFF_ACCFL, 32'h47f3);
        rc(OFF_HL, 32'h1114);
        rc(OFF_BC, 32'h4);
        rc(OFF_PC, 32'h102);
        chk(gap, 32'd21);
        chk(nrf - n0, 32'h4);
        ld(16'h00f3, 16'h7, 16'h1118, 16'h0);
        put(OFF_PC, 32'h200);
        i_bsba_mem.m[16'h1118] = 8'h52;
        i_bsba_mem.m[16'h1117] = 8'h00;
        i_bsba_mem.m[16'h1116] = 8'hf3;
        irq <= 1'h1;
        run({24'h1, OP_SRCH_DN});
        rc(OFF_STATUS, 32'h2);
        rc(OFF_PC, 32'h200);
        irq <= 1'h0;
        run({24'h1, OP_SRCH_DN});
        rc(OFF_HL, 32'h1115);
        rc(OFF_ACCFL, 32'h46f3);
    endtask
    task automatic t_move;
        ld(16'hd7aa, 16'h3, 16'h1114, 16'h2225);
        i_bsba_mem.m[16'h1114] = 8'ha5;
        i_bsba_mem.m[16'h1113] = 8'h36;
        run({24'h1, OP_MOVE_DN});
        rc(OFF_ACCFL, 32'hc1aa);
        rc(OFF_DE, 32'h2222);
        chk({24'h0, i_bsba_mem.m[16'h2224]}, 32'h36);
    endtask
    task automatic t_add;
        logic [7:0] op [8];
        op = '{8'h11, 8'h22, 8'h33, 8'h44, 8'h55, 8'h66, 8'h5a, 8'hbc};
        ld(16'h00bc, 16'h1122, 16'h5566, 16'h3344);
        for (int s = 0; s < 8; s++)
        begin
            put(OFF_ACCFL, 32'hbc);
            run(s == 6 ? {8'h0, 8'h5a, 8'h0, OP_ADD_IMM} : {24'h0, OP_ADD_REG, s[2:0]});
            rc(OFF_ACCFL, {16'h0, add(8'hbc, op[s])});
        end
        get(8'h1c);
        chk({30'h0, rs}, {30'h0, RESP_SLV});
    endtask
    initial
    begin
        repeat (20) @(posedge clk);
        rst_n <= 1'h1;
        t_cmp;
        t_search;
        t_move;
        t_add;
        end_of_test;
    end
    // Cuts a hang short
    initial
    begin
        repeat (20000) @(posedge clk);
        errors = errors + 1;
        end_of_test;
    end
endmodule
`default_nettype wire
